/* feq_pkg.sv */
// constants and types for the flash extended query read-only table
package feq_pkg;

  // query addresses of the extended table
  localparam logic [8:0] EXT_BASE        = 9'h10a;
  localparam logic [8:0] MAJOR_ADDR      = 9'h10d;
  localparam logic [8:0] MINOR_ADDR      = 9'h10e;
  localparam logic [8:0] FEAT_ADDR       = 9'h10f;
  localparam logic [8:0] SUSP_ADDR       = 9'h113;
  localparam logic [8:0] BSTAT_ADDR      = 9'h114;
  localparam logic [8:0] VCC_OPT_ADDR    = 9'h116;
  localparam logic [8:0] VPP_OPT_ADDR    = 9'h117;

  // geometry and erase-region map addresses
  localparam logic [8:0] SIZE_ADDR       = 9'h027;
  localparam logic [8:0] IFACE_ADDR      = 9'h028;
  localparam logic [8:0] WBUF_ADDR       = 9'h02a;
  localparam logic [8:0] NREG_ADDR       = 9'h02c;
  localparam logic [8:0] REG1_ADDR       = 9'h02d;
  localparam logic [8:0] REG2_ADDR       = 9'h031;
  localparam logic [8:0] REG3_ADDR       = 9'h035;
  localparam logic [8:0] REG_END_ADDR    = 9'h038;

  // local control and status registers
  localparam logic [8:0] CFG_ADDR        = 9'h180;
  localparam logic [8:0] STAT_ADDR       = 9'h181;

  // signature and version characters
  localparam logic [7:0] SIG_CHAR0       = 8'h50;
  localparam logic [7:0] SIG_CHAR1       = 8'h52;
  localparam logic [7:0] SIG_CHAR2       = 8'h49;
  localparam logic [7:0] MAJOR_CHAR      = 8'h31;
  localparam logic [7:0] MINOR_CHAR      = 8'h34;

  // optional feature bytes
  localparam logic [7:0] FEAT_BYTE0      = 8'he6;
  localparam logic [7:0] FEAT_BYTE1      = 8'h01;
  localparam logic [7:0] FEAT_BYTE2      = 8'h00;
  localparam logic [7:0] FEAT_BYTE3_ONE  = 8'h00;
  localparam logic [7:0] FEAT_BYTE3_LINK = 8'h40;

  // suspend, block status mask, supply codes
  localparam logic [7:0] SUSP_FUNCS      = 8'h01;
  localparam logic [7:0] BSTAT_LO        = 8'h03;
  localparam logic [7:0] BSTAT_HI        = 8'h00;
  localparam logic [7:0] VCC_OPT_CODE    = 8'h18;
  localparam logic [7:0] VPP_OPT_CODE    = 8'h90;

  // geometry values
  localparam logic [7:0]  DEV_SIZE_LOG2  = 8'h19;
  localparam logic [15:0] IFACE_CODE     = 16'h0001;
  localparam logic [15:0] WBUF_LOG2      = 16'h000a;
  localparam logic [7:0]  NUM_REGIONS    = 8'h02;

  // erase regions: blocks and size in 256-byte units
  localparam logic [15:0] PARAM_BLKS     = 16'd4;
  localparam logic [15:0] PARAM_UNITS    = 16'h0080;
  localparam logic [15:0] MAIN_BLKS      = 16'd255;
  localparam logic [15:0] MAIN_UNITS     = 16'h0200;

  // field positions of the configuration and status registers
  localparam int CFG_STACKED_BIT  = 0;
  localparam int CFG_SECOND_BIT   = 1;
  localparam int CFG_TOP_BIT      = 2;
  localparam int STAT_UNMAP_BIT   = 0;

  typedef struct packed {
    logic top_param;
    logic second_die;
    logic stacked;
  } feq_cfg_t;

endpackage

/* feq_query_rom.sv */
// read-only extended query table with erase-region map behind a plain register port
//
// Our own choice: strobed register access.
`timescale 1ns/10ps

// Functional notes
// - signature bytes 50h 52h 49h from 10Ah
// - major version character 31h at 10Dh
// - minor version character 34h at 10Eh
// - four feature bytes, reserved bits zero
// - lowest feature byte reads E6h
// - second feature byte reads 01h
// - third byte 00h, bit 31 clear
// - top byte 00h single, 40h/00h stacked
// - post-suspend byte reads 01h
// - block status mask reads 03h, 00h
// - core supply optimum code 18h
// - programming supply optimum code 90h
// - region: count minus one, 256-byte units
module feq_query_rom #(
  parameter int         ADDR_W      = 9,
  parameter logic       STACKED_DEF = 1'b0,
  parameter logic       SECOND_DEF  = 1'b0,
  parameter logic       TOP_DEF     = 1'b0
) (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [15:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [15:0]       RDATA_OUT,
  output logic                   RVALID_OUT
);

  generate
    if (ADDR_W != 9) begin : g_bad_addr_w
      $error("feq_query_rom: ADDR_W must be 9");
    end
  endgenerate

  feq_pkg::feq_cfg_t cfg_ff;
  logic              unmap_ff;
  logic [15:0]       rdata_ff;
  logic              rvalid_ff;

  logic [7:0]        rom_byte;
  logic              rom_hit;
  logic [31:0]       region1;
  logic [31:0]       region2;
  logic [31:0]       param_desc;
  logic [31:0]       main_desc;
  logic [31:0]       feat_word;
  logic [7:0]        feat_top;
  logic [8:0]        a;
  logic              unmap_evt;
  logic [15:0]       nxt_rdata;

  assign a = ADDR_IN;

  // region descriptors
  assign param_desc = {feq_pkg::PARAM_UNITS, feq_pkg::PARAM_BLKS - 16'd1};
  assign main_desc  = {feq_pkg::MAIN_UNITS, feq_pkg::MAIN_BLKS - 16'd1};
  assign region1    = cfg_ff.top_param ? main_desc : param_desc;
  assign region2    = cfg_ff.top_param ? param_desc : main_desc;

  // top feature byte depends on die position in a stacked pair
  always_comb begin
    if (cfg_ff.stacked && !cfg_ff.second_die) begin
      feat_top = feq_pkg::FEAT_BYTE3_LINK;
    end else begin
      feat_top = feq_pkg::FEAT_BYTE3_ONE;
    end
  end

  assign feat_word = {feat_top, feq_pkg::FEAT_BYTE2, feq_pkg::FEAT_BYTE1,
                      feq_pkg::FEAT_BYTE0};

  // query byte lookup
  always_comb begin
    rom_byte = 8'h00;
    rom_hit  = 1'b1;
    case (a)
      feq_pkg::EXT_BASE:              rom_byte = feq_pkg::SIG_CHAR0;
      feq_pkg::EXT_BASE + 9'h001:     rom_byte = feq_pkg::SIG_CHAR1;
      feq_pkg::EXT_BASE + 9'h002:     rom_byte = feq_pkg::SIG_CHAR2;
      feq_pkg::MAJOR_ADDR:            rom_byte = feq_pkg::MAJOR_CHAR;
      feq_pkg::MINOR_ADDR:            rom_byte = feq_pkg::MINOR_CHAR;
      feq_pkg::FEAT_ADDR:             rom_byte = feat_word[7:0];
      feq_pkg::FEAT_ADDR + 9'h001:    rom_byte = feat_word[15:8];
      feq_pkg::FEAT_ADDR + 9'h002:    rom_byte = feat_word[23:16];
      feq_pkg::FEAT_ADDR + 9'h003:    rom_byte = feat_word[31:24];
      feq_pkg::SUSP_ADDR:             rom_byte = feq_pkg::SUSP_FUNCS;
      feq_pkg::BSTAT_ADDR:            rom_byte = feq_pkg::BSTAT_LO;
      feq_pkg::BSTAT_ADDR + 9'h001:   rom_byte = feq_pkg::BSTAT_HI;
      feq_pkg::VCC_OPT_ADDR:          rom_byte = feq_pkg::VCC_OPT_CODE;
      feq_pkg::VPP_OPT_ADDR:          rom_byte = feq_pkg::VPP_OPT_CODE;
      feq_pkg::SIZE_ADDR:             rom_byte = feq_pkg::DEV_SIZE_LOG2;
      feq_pkg::IFACE_ADDR:            rom_byte = feq_pkg::IFACE_CODE[7:0];
      feq_pkg::IFACE_ADDR + 9'h001:   rom_byte = feq_pkg::IFACE_CODE[15:8];
      feq_pkg::WBUF_ADDR:             rom_byte = feq_pkg::WBUF_LOG2[7:0];
      feq_pkg::WBUF_ADDR + 9'h001:    rom_byte = feq_pkg::WBUF_LOG2[15:8];
      feq_pkg::NREG_ADDR:             rom_byte = feq_pkg::NUM_REGIONS;
      feq_pkg::REG1_ADDR:             rom_byte = region1[7:0];
      feq_pkg::REG1_ADDR + 9'h001:    rom_byte = region1[15:8];
      feq_pkg::REG1_ADDR + 9'h002:    rom_byte = region1[23:16];
      feq_pkg::REG1_ADDR + 9'h003:    rom_byte = region1[31:24];
      feq_pkg::REG2_ADDR:             rom_byte = region2[7:0];
      feq_pkg::REG2_ADDR + 9'h001:    rom_byte = region2[15:8];
      feq_pkg::REG2_ADDR + 9'h002:    rom_byte = region2[23:16];
      feq_pkg::REG2_ADDR + 9'h003:    rom_byte = region2[31:24];
      feq_pkg::REG3_ADDR,
      feq_pkg::REG3_ADDR + 9'h001,
      feq_pkg::REG3_ADDR + 9'h002,
      feq_pkg::REG_END_ADDR:          rom_byte = 8'h00;
      default:                        rom_hit  = 1'b0;
    endcase
  end

  // read mux: query codes on the low byte only
  always_comb begin
    nxt_rdata = 16'h0000;
    unmap_evt = 1'b0;
    if (RD_IN) begin
      if (rom_hit) begin
        nxt_rdata = {8'h00, rom_byte};
      end else if (a == feq_pkg::CFG_ADDR) begin
        nxt_rdata = {13'h0000, cfg_ff};
      end else if (a == feq_pkg::STAT_ADDR) begin
        nxt_rdata = {15'h0000, unmap_ff};
      end else begin
        unmap_evt = 1'b1;
      end
    end else if (WR_IN && (a != feq_pkg::CFG_ADDR) && (a != feq_pkg::STAT_ADDR)) begin
      unmap_evt = 1'b1;
    end
  end

  // read data stands for the one cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= RD_IN;
    end
  end

  // die configuration register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cfg_ff.stacked    <= STACKED_DEF;
      cfg_ff.second_die <= SECOND_DEF;
      cfg_ff.top_param  <= TOP_DEF;
    end else if (WR_IN && (a == feq_pkg::CFG_ADDR)) begin
      cfg_ff.stacked    <= WDATA_IN[feq_pkg::CFG_STACKED_BIT];
      cfg_ff.second_die <= WDATA_IN[feq_pkg::CFG_SECOND_BIT];
      cfg_ff.top_param  <= WDATA_IN[feq_pkg::CFG_TOP_BIT];
    end
  end

  // sticky unmapped-access flag, write one to clear, set wins
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      unmap_ff <= 1'b0;
    end else if (unmap_evt) begin
      unmap_ff <= 1'b1;
    end else if (WR_IN && (a == feq_pkg::STAT_ADDR) && WDATA_IN[feq_pkg::STAT_UNMAP_BIT]) begin
      unmap_ff <= 1'b0;
    end
  end

  assign RDATA_OUT  = rdata_ff;
  assign RVALID_OUT = rvalid_ff;

endmodule // feq_query_rom

/* feq_query_rom_properties.sv */
// port assertions for the extended query table
`timescale 1ns/10ps
module feq_query_rom_properties #(
  parameter int ADDR_W = 9
) (
  input wire logic              CLK_IN,
  input wire logic              RST_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [15:0]       WDATA_IN,
  input wire logic              WR_IN,
  input wire logic              RD_IN,
  input wire logic [15:0]       RDATA_OUT,
  input wire logic              RVALID_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property rd_p(a, d);
    RD_IN && ADDR_IN == a |=> RVALID_OUT && RDATA_OUT == d;
  endproperty
  sig_byte_a: assert property (rd_p(9'h10a, 16'h0050)) else $error("sig");
  major_ver_a: assert property (rd_p(9'h10d, 16'h0031)) else $error("major");
  minor_ver_a: assert property (rd_p(9'h10e, 16'h0034)) else $error("minor");
  feat_low_a: assert property (rd_p(9'h10f, 16'h00e6)) else $error("feat");
  feat_top_a: assert property (RVALID_OUT && $past(ADDR_IN) == 9'h112 |->
    RDATA_OUT[7] == 1'b0 && RDATA_OUT[5:0] == 6'h00) else $error("top");
  susp_func_a: assert property (rd_p(9'h113, 16'h0001)) else $error("susp");
  bstat_mask_a: assert property (rd_p(9'h114, 16'h0003)) else $error("bstat");
  vcc_code_a: assert property (rd_p(9'h116, 16'h0018)) else $error("vcc");
  vpp_code_a: assert property (rd_p(9'h117, 16'h0090)) else $error("vpp");
  upper_zero_a: assert property (RDATA_OUT[15:8] == 8'h00) else $error("upper");
  cover property (RD_IN && ADDR_IN == 9'h112);
  cover property (WR_IN && ADDR_IN == 9'h180);
  cover property (RVALID_OUT && RDATA_OUT == 16'h0040);
endmodule // feq_query_rom_properties

/* feq_host_model.sv */
// host model issuing single-cycle reads and writes
`timescale 1ns/10ps
module feq_host_model (
  input  wire logic        clk_in,
  output logic      [8:0]  addr_out = 9'h000,
  output logic      [15:0] wdata_out = 16'h0000,
  output logic             wr_out = 1'b0,
  output logic             rd_out = 1'b0,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in
);
  // released lines show the inverse of the last value
  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
    v = rvalid_in;
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] w);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= w;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~w;
  endtask
endmodule // feq_host_model

/* test_feq_query_rom.sv */
// self-checking bench for the extended query table
`timescale 1ns/10ps
module test_feq_query_rom;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr;
  logic        rd;
  logic        rvalid;
  int          n_fail = 0;
  int          compares = 0;
  always #2.5 clk = ~clk;
  feq_query_rom i_dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RVALID_OUT(rvalid));
  feq_host_model i_host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));
  task automatic q(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] got;
    logic        v;
    i_host.rd(a, got, v);
    compares++;
    if (got !== exp || v !== 1'b1) begin
      n_fail++;
      $display("BAD %0t read %h got %h want %h", $time, a, got, exp);
    end
  endtask
  task automatic t_table;
    q(9'h10a, 16'h0050);
    q(9'h10b, 16'h0052);
    q(9'h10c, 16'h0049);
    q(9'h10d, 16'h0031);
    q(9'h10e, 16'h0034);
    q(9'h10f, 16'h00e6);
    q(9'h110, 16'h0001);
    q(9'h111, 16'h0000);
    q(9'h112, 16'h0000);
    q(9'h113, 16'h0001);
    q(9'h114, 16'h0003);
    q(9'h115, 16'h0000);
    q(9'h116, 16'h0018);
    q(9'h117, 16'h0090);
  endtask
  task automatic t_dies;
    i_host.wr(9'h180, 16'h0001);
    q(9'h112, 16'h0040);
    i_host.wr(9'h180, 16'h0003);
    q(9'h112, 16'h0000);
  endtask
  task automatic t_regions;
    i_host.wr(9'h180, 16'h0000);
    q(9'h02d, 16'h0003);
    q(9'h02f, 16'h0080);
    q(9'h031, 16'h00fe);
    q(9'h034, 16'h0002);
    i_host.wr(9'h180, 16'h0004);
    q(9'h02d, 16'h00fe);
    q(9'h033, 16'h0080);
    q(9'h027, 16'h0019);
    q(9'h028, 16'h0001);
    q(9'h02a, 16'h000a);
    q(9'h02c, 16'h0002);
    q(9'h035, 16'h0000);
    q(9'h038, 16'h0000);
  endtask
  task automatic t_refuse;
    q(9'h181, 16'h0000);
    i_host.wr(9'h10f, 16'hffff);
    q(9'h10f, 16'h00e6);
    q(9'h181, 16'h0001);
    i_host.wr(9'h181, 16'h0001);
    q(9'h181, 16'h0000);
    q(9'h026, 16'h0000);
    q(9'h181, 16'h0001);
  endtask
  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_refuse;
    t_table;
    t_dies;
    t_regions;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule // test_feq_query_rom
bind feq_query_rom feq_query_rom_properties #(.ADDR_W(ADDR_W)) i_chk (.CLK_IN, .RST_IN,
  .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .RVALID_OUT);
